//--- core/dbg_sb_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbg_sb_consts.svh"
module dbg_sb_device #(
  parameter int NCORES = `NCORES_DEF // Number of cores served
) (
  input wire logic clk_i, // Processor clock
  input wire logic rst_n_i, // Synchronous reset, active low
  dbg_sb_if.device link, // Sideband toward debugger and trace logic
  input wire logic [NCORES-1:0] rx_fill_i, // Debugger wrote receive half
  input wire logic [NCORES-1:0] rx_drain_i, // Core read receive half
  input wire logic [NCORES-1:0] tx_fill_i, // Core wrote transmit half
  input wire logic [NCORES-1:0] tx_drain_i, // Debugger read transmit half
  input wire logic [NCORES-1:0] no_powerdown_req_i, // Debugger asks core stay powered
  input wire logic [NCORES-1:0] reg_wr_i, // Debug register write attempt
  input wire logic [NCORES-1:0] reg_wr_ext_i, // Attempt comes from external debugger
  input wire logic [NCORES-1:0] core_halted_i, // Core sits in halted debug state
  input wire logic [NCORES-1:0] wfi_entering_i, // Core attempting wait entry
  input wire dbg_sb_pkg::ictl_t [NCORES-1:0] instr_ctrl_i, // Instruction trace control
  input wire dbg_sb_pkg::word_t [NCORES-1:0] instr_addr_i, // Instruction address
  input wire dbg_sb_pkg::dctl_t [NCORES-1:0] data_ctrl_i, // Data trace control
  input wire dbg_sb_pkg::word_t [NCORES-1:0] data_addr_i, // Data address
  input wire dbg_sb_pkg::word_t [NCORES-1:0] data_value_i, // Data write value
  input wire dbg_sb_pkg::word_t [NCORES-1:0] context_id_i, // Current context identifier
  input wire dbg_sb_pkg::perf_t [NCORES-1:0] perf_event_i, // Performance events
  output logic [NCORES-1:0] reg_wr_grant_o, // Write attempt allowed
  output logic [NCORES-1:0] halt_request_o, // External halt request seen
  output logic [NCORES-1:0] trace_powered_o, // Trace port powered
  output dbg_sb_pkg::ext_ev_t [NCORES-1:0] ext_event_o, // External events to monitor
  output dbg_sb_pkg::word_t rom_table_addr_o, // ROM table physical address
  output dbg_sb_pkg::word_t debug_regs_addr_o, // Debug registers physical address
  output logic rom_table_ok_o, // ROM table address known
  output logic debug_regs_ok_o // Debug register address known
);
  import dbg_sb_pkg::*;

  // Only up to four cores fit the controller's per-core register fields
  if (NCORES < 1 || NCORES > 4) begin : g_bad_ncores
    $error("dbg_sb_device: NCORES must be 1 to 4");
  end

  // Flag and request state
  logic [NCORES-1:0] rxf_q;
  logic [NCORES-1:0] rxf_d;
  logic [NCORES-1:0] txe_q;
  logic [NCORES-1:0] txe_d;
  logic [NCORES-1:0] kpw_q;
  logic [NCORES-1:0] ack_q;
  logic [NCORES-1:0] wfi_q;
  logic [NCORES-1:0] hreq_q;
  logic [NCORES-1:0] grant_q;
  logic [NCORES-1:0] grant_d;
  logic [NCORES-1:0] tpwr_q;
  ext_ev_t [NCORES-1:0] ev_q;

  // Trace output stage
  ictl_t [NCORES-1:0] ictl_q;
  ictl_t [NCORES-1:0] ictl_d;
  word_t [NCORES-1:0] iaddr_q;
  word_t [NCORES-1:0] iaddr_d;
  dctl_t [NCORES-1:0] dctl_q;
  dctl_t [NCORES-1:0] dctl_d;
  word_t [NCORES-1:0] daddr_q;
  word_t [NCORES-1:0] daddr_d;
  word_t [NCORES-1:0] ddata_q;
  word_t [NCORES-1:0] ddata_d;
  word_t [NCORES-1:0] cid_q;
  word_t [NCORES-1:0] cid_d;
  perf_t [NCORES-1:0] perf_q;
  perf_t [NCORES-1:0] perf_d;

  // Strap capture
  logic strap_done_q;
  word_t rom_q;
  word_t rom_d;
  word_t dregs_q;
  word_t dregs_d;
  logic rom_ok_q;
  logic dregs_ok_q;

  // Per-core next values; one loop keeps the cores identical
  for (genvar g = 0; g < NCORES; g++) begin : g_core
    // Fresh data beats a same-cycle read, so the flag stays full
    assign rxf_d[g] = rx_fill_i[g] | (rxf_q[g] & ~rx_drain_i[g]);
    // A core write in the same cycle as a debugger read leaves it full
    assign txe_d[g] = ~tx_fill_i[g] & (tx_drain_i[g] | txe_q[g]);
    // External writes always pass; others only while the lock is low
    assign grant_d[g] = reg_wr_i[g] & (reg_wr_ext_i[g] | ~link.external_only_debug_write[g]);
    // Trace buses rest at zero while the trace port is unpowered, saving toggles
    assign ictl_d[g] = link.trace_power_up[g] ? instr_ctrl_i[g] : '0;
    assign iaddr_d[g] = link.trace_power_up[g] ? instr_addr_i[g] : '0;
    assign dctl_d[g] = link.trace_power_up[g] ? data_ctrl_i[g] : '0;
    assign daddr_d[g] = link.trace_power_up[g] ? data_addr_i[g] : '0;
    assign ddata_d[g] = link.trace_power_up[g] ? data_value_i[g] : '0;
    assign cid_d[g] = link.trace_power_up[g] ? context_id_i[g] : '0;
    assign perf_d[g] = link.trace_power_up[g] ? perf_event_i[g] : '0;
  end

  // Address arithmetic: offset is two's complement, the sum wraps at 32 bits
  assign rom_d = {link.rom_table_base, `ROM_BASE_LSB'(0)};
  assign dregs_d = rom_d + {link.debug_self_offset, `SELF_OFF_LSB'(0)};

  // Debug flags; registered so the far side never sees decode glitches
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rxf_q <= '0;
      txe_q <= '1;
      kpw_q <= '0;
      ack_q <= '0;
      hreq_q <= '0;
      grant_q <= '0;
    end else begin
      rxf_q <= rxf_d;
      txe_q <= txe_d;
      kpw_q <= no_powerdown_req_i;
      ack_q <= core_halted_i;
      hreq_q <= link.external_halt_request;
      grant_q <= grant_d;
    end
  end

  // Trace stage, all on clk_i; no second clock exists
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tpwr_q <= '0;
      ev_q <= '0;
      wfi_q <= '0;
      ictl_q <= '0;
      iaddr_q <= '0;
      dctl_q <= '0;
      daddr_q <= '0;
      ddata_q <= '0;
      cid_q <= '0;
      perf_q <= '0;
    end else begin
      tpwr_q <= link.trace_power_up;
      ev_q <= link.trace_external_event;
      wfi_q <= wfi_entering_i;
      ictl_q <= ictl_d;
      iaddr_q <= iaddr_d;
      dctl_q <= dctl_d;
      daddr_q <= daddr_d;
      ddata_q <= ddata_d;
      cid_q <= cid_d;
      perf_q <= perf_d;
    end
  end

  // Straps are caught once, on the first edge after reset release
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      strap_done_q <= 1'b0;
      rom_q <= '0;
      dregs_q <= '0;
      rom_ok_q <= 1'b0;
      dregs_ok_q <= 1'b0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      rom_q <= rom_d;
      dregs_q <= dregs_d;
      rom_ok_q <= link.rom_table_base_valid;
      // A self offset only means something relative to a known ROM base
      dregs_ok_q <= link.rom_table_base_valid & link.debug_self_offset_valid;
    end
  end

  // Link outputs
  assign link.dtr_receive_full = rxf_q;
  assign link.dtr_transmit_empty = txe_q;
  assign link.keep_powered_request = kpw_q;
  assign link.halt_acknowledge = ack_q;
  assign link.wait_entry_pending = wfi_q;
  assign link.instr_trace_ctrl = ictl_q;
  assign link.instr_trace_address = iaddr_q;
  assign link.data_trace_ctrl = dctl_q;
  assign link.data_trace_address = daddr_q;
  assign link.data_trace_write_value = ddata_q;
  assign link.trace_context_id = cid_q;
  assign link.perf_event_bus = perf_q;

  // User-side outputs
  assign reg_wr_grant_o = grant_q;
  assign halt_request_o = hreq_q;
  assign trace_powered_o = tpwr_q;
  assign ext_event_o = ev_q;
  assign rom_table_addr_o = rom_q;
  assign debug_regs_addr_o = dregs_q;
  assign rom_table_ok_o = rom_ok_q;
  assign debug_regs_ok_o = dregs_ok_q;
endmodule : dbg_sb_device
`default_nettype wire

//--- core/dbg_sb_consts.svh
`ifndef DBG_SB_CONSTS_SVH
`define DBG_SB_CONSTS_SVH

// Core count and sideband field widths
`define NCORES_DEF 4
`define ICTL_W 20
`define DCTL_W 11
`define PERF_W 30
`define EXT_EV_W 2
`define ROM_BASE_LSB 12
`define SELF_OFF_LSB 15

// Controller register offsets (byte addresses)
`define REG_CTRL 8'h00
`define REG_EXT_EV 8'h04
`define REG_FLAGS 8'h08
`define REG_IRQ_STAT 8'h0C
`define REG_IRQ_MASK 8'h10
`define REG_TRACE_SEL 8'h14
`define REG_T_ICTL 8'h18
`define REG_T_IADDR 8'h1C
`define REG_T_DCTL 8'h20
`define REG_T_DADDR 8'h24
`define REG_T_DDATA 8'h28
`define REG_T_CID 8'h2C
`define REG_T_PERF 8'h30

// Field positions: four bits per field, one bit per core
`define CTRL_EXTONLY_LSB 0
`define CTRL_TPWR_LSB 4
`define CTRL_HALT_LSB 8
`define FLG_RXF_LSB 0
`define FLG_TXE_LSB 4
`define FLG_KPW_LSB 8
`define FLG_ACK_LSB 12
`define FLG_WFI_LSB 16

// Reset values
`define CTRL_RST 32'h0000_0000
`define IRQ_MASK_RST 16'h0000
`define EXT_EV_RST 8'h00

`endif

//--- core/dbg_sb_pkg.sv
`include "dbg_sb_consts.svh"
package dbg_sb_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0] reg_addr_t;
  typedef logic [`ICTL_W-1:0] ictl_t;
  typedef logic [`DCTL_W-1:0] dctl_t;
  typedef logic [`PERF_W-1:0] perf_t;
  typedef logic [`EXT_EV_W-1:0] ext_ev_t;
  typedef logic [31-`ROM_BASE_LSB:0] rom_base_t;
  typedef logic [31-`SELF_OFF_LSB:0] self_off_t;
endpackage : dbg_sb_pkg

//--- core/dbg_sb_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dbg_sb_if #(parameter int NCORES = 4) (
  input wire logic clk_i // Shared processor clock
);
  // Debug side
  logic [NCORES-1:0] dtr_receive_full;
  logic [NCORES-1:0] dtr_transmit_empty;
  logic [NCORES-1:0] keep_powered_request;
  logic [NCORES-1:0] external_only_debug_write;
  logic [NCORES-1:0] external_halt_request;
  logic [NCORES-1:0] halt_acknowledge;
  dbg_sb_pkg::rom_base_t rom_table_base;
  logic rom_table_base_valid;
  dbg_sb_pkg::self_off_t debug_self_offset;
  logic debug_self_offset_valid;
  // Trace side, all on the same clock
  dbg_sb_pkg::ictl_t [NCORES-1:0] instr_trace_ctrl;
  dbg_sb_pkg::word_t [NCORES-1:0] instr_trace_address;
  dbg_sb_pkg::dctl_t [NCORES-1:0] data_trace_ctrl;
  dbg_sb_pkg::word_t [NCORES-1:0] data_trace_address;
  dbg_sb_pkg::word_t [NCORES-1:0] data_trace_write_value;
  dbg_sb_pkg::word_t [NCORES-1:0] trace_context_id;
  logic [NCORES-1:0] wait_entry_pending;
  dbg_sb_pkg::perf_t [NCORES-1:0] perf_event_bus;
  logic [NCORES-1:0] trace_power_up;
  dbg_sb_pkg::ext_ev_t [NCORES-1:0] trace_external_event;

  modport device (
    output dtr_receive_full, dtr_transmit_empty, keep_powered_request, halt_acknowledge,
    output instr_trace_ctrl, instr_trace_address, data_trace_ctrl, data_trace_address,
    output data_trace_write_value, trace_context_id, wait_entry_pending, perf_event_bus,
    input external_only_debug_write, external_halt_request, rom_table_base, rom_table_base_valid,
    input debug_self_offset, debug_self_offset_valid, trace_power_up, trace_external_event
  );
  modport ext (
    input dtr_receive_full, dtr_transmit_empty, keep_powered_request, halt_acknowledge,
    input instr_trace_ctrl, instr_trace_address, data_trace_ctrl, data_trace_address,
    input data_trace_write_value, trace_context_id, wait_entry_pending, perf_event_bus,
    output external_only_debug_write, external_halt_request, rom_table_base, rom_table_base_valid,
    output debug_self_offset, debug_self_offset_valid, trace_power_up, trace_external_event
  );
endinterface : dbg_sb_if
`default_nettype wire

//--- core/dbg_sb_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbg_sb_consts.svh"
module dbg_sb_ctrl #(
  parameter int NCORES = `NCORES_DEF, // Number of cores served
  parameter logic [19:0] ROM_BASE = 20'h00000, // ROM table base bits 31:12
  parameter bit ROM_VALID = 1'b0, // ROM base known
  parameter logic [16:0] SELF_OFFSET = 17'h00000, // Self offset bits 31:15
  parameter bit SELF_VALID = 1'b0 // Self offset known
) (
  input wire logic clk_i, // Processor clock
  input wire logic rst_n_i, // Synchronous reset, active low
  dbg_sb_if.ext link, // Sideband toward the device
  input wire dbg_sb_pkg::reg_addr_t addr_i, // Register byte address
  input wire dbg_sb_pkg::word_t wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output dbg_sb_pkg::word_t rdata_o, // Read data, cycle after rd_i
  output logic irq_o // Level interrupt
);
  import dbg_sb_pkg::*;

  if (NCORES < 1 || NCORES > 4) begin : g_bad_ncores
    $error("dbg_sb_ctrl: NCORES must be 1 to 4");
  end

  // Widen a per-core vector into a four-bit register field
  function automatic logic [3:0] fld(input logic [NCORES-1:0] v);
    fld = '0;
    fld[NCORES-1:0] = v;
  endfunction : fld

  logic [NCORES-1:0] xonly_q;
  logic [NCORES-1:0] tpwr_q;
  logic [NCORES-1:0] halt_q;
  logic [NCORES-1:0] halt_d;
  logic [7:0] ev_q;
  logic [1:0] sel_q;
  logic [15:0] stat_q;
  logic [15:0] stat_d;
  logic [15:0] mask_q;
  logic [15:0] flags_prev_q;
  word_t rdata_q;
  logic irq_q;
  rom_base_t rom_q;
  self_off_t self_q;
  logic rom_v_q;
  logic self_v_q;

  // Register decode
  wire logic wr_ctrl = wr_i && addr_i == `REG_CTRL;
  wire logic rd_stat = rd_i && addr_i == `REG_IRQ_STAT;
  wire logic [15:0] flags_now = {fld(link.wait_entry_pending), fld(link.halt_acknowledge),
                                 fld(link.dtr_transmit_empty), fld(link.dtr_receive_full)};
  // Rising edges of full, empty, acknowledge and wait pending are the events
  wire logic [15:0] events = flags_now & ~flags_prev_q;
  wire logic [31:0] flags_word = {12'h000, fld(link.wait_entry_pending), fld(link.halt_acknowledge),
                                  fld(link.keep_powered_request), fld(link.dtr_transmit_empty),
                                  fld(link.dtr_receive_full)};
  wire logic [31:0] ctrl_word = {20'h00000, fld(halt_q), fld(tpwr_q), fld(xonly_q)};
  wire logic [NCORES-1:0] halt_wr = wdata_i[`CTRL_HALT_LSB +: NCORES];

  // A pending request stays up until acknowledged, so a write can only add requests
  assign halt_d = (wr_ctrl ? halt_wr : '0) | (halt_q & ~link.halt_acknowledge);
  // Set beats the read-clear so an event landing on the read is kept
  assign stat_d = (stat_q & ~{16{rd_stat}}) | events;

  // Snapshot of the selected core's trace; reads past NCORES show zero
  wire logic sel_ok = 32'(sel_q) < NCORES;
  wire logic [1:0] s = sel_ok ? sel_q : 2'h0;
  wire word_t rd_mux =
    addr_i == `REG_CTRL ? ctrl_word :
    addr_i == `REG_EXT_EV ? {24'h000000, ev_q} :
    addr_i == `REG_FLAGS ? flags_word :
    addr_i == `REG_IRQ_STAT ? {16'h0000, stat_q} :
    addr_i == `REG_IRQ_MASK ? {16'h0000, mask_q} :
    addr_i == `REG_TRACE_SEL ? {30'h00000000, sel_q} :
    !sel_ok ? 32'h00000000 :
    addr_i == `REG_T_ICTL ? {12'h000, link.instr_trace_ctrl[s]} :
    addr_i == `REG_T_IADDR ? link.instr_trace_address[s] :
    addr_i == `REG_T_DCTL ? {21'h000000, link.data_trace_ctrl[s]} :
    addr_i == `REG_T_DADDR ? link.data_trace_address[s] :
    addr_i == `REG_T_DDATA ? link.data_trace_write_value[s] :
    addr_i == `REG_T_CID ? link.trace_context_id[s] :
    addr_i == `REG_T_PERF ? {2'h0, link.perf_event_bus[s]} : 32'h00000000;

  // Software registers and link drivers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      xonly_q <= '0;
      tpwr_q <= '0;
      halt_q <= '0;
      ev_q <= `EXT_EV_RST;
      sel_q <= 2'h0;
      mask_q <= `IRQ_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        xonly_q <= wdata_i[`CTRL_EXTONLY_LSB +: NCORES];
        tpwr_q <= wdata_i[`CTRL_TPWR_LSB +: NCORES];
      end
      halt_q <= halt_d;
      if (wr_i && addr_i == `REG_EXT_EV) ev_q <= wdata_i[7:0];
      if (wr_i && addr_i == `REG_TRACE_SEL) sel_q <= wdata_i[1:0];
      if (wr_i && addr_i == `REG_IRQ_MASK) mask_q <= wdata_i[15:0];
    end
  end

  // Status, interrupt, read data and strapped values
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      stat_q <= '0;
      flags_prev_q <= '0;
      irq_q <= 1'b0;
      rdata_q <= '0;
      rom_q <= ROM_VALID ? ROM_BASE : '0;
      rom_v_q <= ROM_VALID;
      self_q <= SELF_VALID ? SELF_OFFSET : '0;
      self_v_q <= SELF_VALID;
    end else begin
      stat_q <= stat_d;
      flags_prev_q <= flags_now;
      irq_q <= |(stat_d & mask_q);
      rdata_q <= rd_i ? rd_mux : '0;
    end
  end

  // Link outputs
  assign link.external_only_debug_write = xonly_q;
  assign link.trace_power_up = tpwr_q;
  assign link.external_halt_request = halt_q;
  for (genvar g = 0; g < NCORES; g++) begin : g_ev
    assign link.trace_external_event[g] = ev_q[2*g +: 2];
  end
  assign link.rom_table_base = rom_q;
  assign link.rom_table_base_valid = rom_v_q;
  assign link.debug_self_offset = self_q;
  assign link.debug_self_offset_valid = self_v_q;
  assign rdata_o = rdata_q;
  assign irq_o = irq_q;
endmodule : dbg_sb_ctrl
`default_nettype wire

//--- sim/dbg_sb_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module dbg_sb_monitor #(
  parameter int NCORES = 4 // Cores watched
) (
  input wire logic clk_i, // Processor clock
  input wire logic rst_n_i, // Synchronous reset, active low
  input wire logic [NCORES-1:0] external_halt_request, // Halt request
  input wire logic [NCORES-1:0] halt_acknowledge, // Halt acknowledge
  input wire logic [NCORES-1:0] trace_power_up, // Trace power-up
  input wire dbg_sb_pkg::rom_base_t rom_table_base, // ROM base strap
  input wire logic rom_table_base_valid, // ROM base qualifier
  input wire dbg_sb_pkg::self_off_t debug_self_offset, // Self offset strap
  input wire logic debug_self_offset_valid, // Self offset qualifier
  input wire dbg_sb_pkg::ictl_t [NCORES-1:0] instr_trace_ctrl, // Instr control
  input wire dbg_sb_pkg::word_t [NCORES-1:0] instr_trace_address, // Instr address
  input wire dbg_sb_pkg::dctl_t [NCORES-1:0] data_trace_ctrl, // Data control
  input wire dbg_sb_pkg::word_t [NCORES-1:0] data_trace_address, // Data address
  input wire dbg_sb_pkg::word_t [NCORES-1:0] data_trace_write_value, // Write value
  input wire dbg_sb_pkg::word_t [NCORES-1:0] trace_context_id, // Context id
  input wire dbg_sb_pkg::perf_t [NCORES-1:0] perf_event_bus // Event bus
);
  import dbg_sb_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Straps are wiring, so they never move while running
  a_straps_stable: assert property ($stable({rom_table_base, rom_table_base_valid}))
    else $error("ROM base strap moved");
  a_self_tied: assert property (!debug_self_offset_valid |->
    debug_self_offset == '0 && $stable(debug_self_offset))
    else $error("Unqualified self offset not zero");
  for (genvar g = 0; g < NCORES; g++) begin : g_core
    // Halt handshake: held as a level, dropped one cycle after acknowledge
    sequence s_halt_ack;
      $rose(halt_acknowledge[g]) && external_halt_request[g];
    endsequence
    sequence s_halt_wait;
      external_halt_request[g] && !halt_acknowledge[g];
    endsequence
    a_halt_held: assert property (s_halt_wait |=> external_halt_request[g])
      else $error("Halt request dropped early");
    a_halt_dropped: assert property (s_halt_ack |=> !external_halt_request[g])
      else $error("Halt request kept after acknowledge");
    // Unpowered trace port shows zero one cycle later
    a_instr_gated: assert property (!trace_power_up[g] |=>
      instr_trace_ctrl[g] == '0 && instr_trace_address[g] == '0)
      else $error("Instruction trace not gated");
    a_data_gated: assert property (!trace_power_up[g] |=>
      data_trace_ctrl[g] == '0 && data_trace_address[g] == '0 && data_trace_write_value[g] == '0)
      else $error("Data trace not gated");
    a_ctx_gated: assert property (!trace_power_up[g] |=> trace_context_id[g] == '0)
      else $error("Context id not gated");
    a_perf_gated: assert property (!trace_power_up[g] |=> perf_event_bus[g] == '0)
      else $error("Event bus not gated");
  end
endmodule : dbg_sb_monitor
`default_nettype wire

//--- sim/debug_sideband_signals_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dbg_sb_consts.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module debug_sideband_signals_bench;
  import dbg_sb_pkg::*;
  localparam int NC = 4;
  localparam logic [19:0] RB = 20'hABCDE;
  logic clk_i, rst_n_i, wr, rd, irq, rom_ok, dbg_ok;
  logic [NC-1:0] rx_fill, rx_drain, tx_fill, tx_drain, npd, rwr, rext, halted, wait_for_interrupt_state, grant, hreq, tpw;
  ictl_t [NC-1:0] ictl;
  dctl_t [NC-1:0] dctl;
  perf_t [NC-1:0] perf;
  word_t [NC-1:0] iaddr, daddr, dval, cid;
  ext_ev_t [NC-1:0] evo;
  word_t rom_a, dbg_a, wdata, rdata, ctrl_m, ev_m;
  reg_addr_t addr;
  int err_count, total_checks, seed;
  bit rnd_on, chk_on;
  // Reference model state, one cycle behind the inputs
  logic [NC-1:0] e_rx, e_tx, e_kp, e_ack, e_gr, e_hr, e_tp, e_wp;
  ext_ev_t [NC-1:0] e_ev;
  ictl_t [NC-1:0] e_ic;
  perf_t [NC-1:0] e_pf;
  word_t [NC-1:0] e_ci, e_ia, e_da, e_dd;
  dctl_t [NC-1:0] e_dc;

  dbg_sb_if #(.NCORES(NC)) lk (.clk_i(clk_i));
  dbg_sb_device #(.NCORES(NC)) dbg_sb_device_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(lk),
    .rx_fill_i(rx_fill), .rx_drain_i(rx_drain), .tx_fill_i(tx_fill), .tx_drain_i(tx_drain),
    .no_powerdown_req_i(npd), .reg_wr_i(rwr), .reg_wr_ext_i(rext), .core_halted_i(halted),
    .wfi_entering_i(wait_for_interrupt_state), .instr_ctrl_i(ictl), .instr_addr_i(iaddr), .data_ctrl_i(dctl), .data_addr_i(daddr),
    .data_value_i(dval), .context_id_i(cid), .perf_event_i(perf), .reg_wr_grant_o(grant), .halt_request_o(hreq),
    .trace_powered_o(tpw), .ext_event_o(evo), .rom_table_addr_o(rom_a), .debug_regs_addr_o(dbg_a),
    .rom_table_ok_o(rom_ok), .debug_regs_ok_o(dbg_ok));
  // Self offset given but marked unknown, so the controller must hide it
  dbg_sb_ctrl #(.NCORES(NC), .ROM_BASE(RB), .ROM_VALID(1'b1), .SELF_OFFSET(17'h1FFFF), .SELF_VALID(1'b0))
    dbg_sb_ctrl_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(lk), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq));
  dbg_sb_monitor #(.NCORES(NC)) dbg_sb_monitor_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .external_halt_request(lk.external_halt_request), .halt_acknowledge(lk.halt_acknowledge),
    .trace_power_up(lk.trace_power_up), .rom_table_base(lk.rom_table_base),
    .rom_table_base_valid(lk.rom_table_base_valid), .debug_self_offset(lk.debug_self_offset),
    .debug_self_offset_valid(lk.debug_self_offset_valid), .instr_trace_ctrl(lk.instr_trace_ctrl),
    .instr_trace_address(lk.instr_trace_address), .data_trace_ctrl(lk.data_trace_ctrl),
    .data_trace_address(lk.data_trace_address), .data_trace_write_value(lk.data_trace_write_value),
    .trace_context_id(lk.trace_context_id), .perf_event_bus(lk.perf_event_bus));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [127:0] r128();
    r128 = {$random(seed), $random(seed), $random(seed), $random(seed)};
  endfunction : r128

  // Random stimulus on every device input while enabled
  always @(posedge clk_i) begin
    if (rnd_on) begin
      {rx_fill, rx_drain, tx_fill, tx_drain, npd, rwr, rext, halted} <= 32'($random(seed));
      wait_for_interrupt_state <= 4'($random(seed));
      ictl <= 80'(r128());
      dctl <= 44'(r128());
      perf <= 120'(r128());
      iaddr <= r128();
      daddr <= r128();
      dval <= r128();
      cid <= r128();
    end
  end

  // Model: fill wins over drain on both halves of the transfer register
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      e_rx <= '0;
      e_tx <= '1;
    end else begin
      e_rx <= rx_fill | (e_rx & ~rx_drain);
      e_tx <= ~tx_fill & (e_tx | tx_drain);
      e_kp <= npd;
      e_ack <= halted;
      e_gr <= rwr & (rext | ~lk.external_only_debug_write);
      e_hr <= lk.external_halt_request;
      e_tp <= lk.trace_power_up;
      e_ev <= lk.trace_external_event;
      e_wp <= wait_for_interrupt_state;
      for (int g = 0; g < NC; g++) begin
        e_ic[g] <= lk.trace_power_up[g] ? ictl[g] : '0;
        e_ci[g] <= lk.trace_power_up[g] ? cid[g] : '0;
        e_pf[g] <= lk.trace_power_up[g] ? perf[g] : '0;
        e_ia[g] <= lk.trace_power_up[g] ? iaddr[g] : '0;
        e_dc[g] <= lk.trace_power_up[g] ? dctl[g] : '0;
        e_da[g] <= lk.trace_power_up[g] ? daddr[g] : '0;
        e_dd[g] <= lk.trace_power_up[g] ? dval[g] : '0;
      end
    end
  end

  // Compare every per-core result and every link signal but the halt request and straps mid-cycle, when all updates have settled
  always @(negedge clk_i) begin
    if (chk_on) begin
      `CHK(lk.dtr_receive_full, e_rx)
      `CHK(lk.dtr_transmit_empty, e_tx)
      `CHK(lk.keep_powered_request, e_kp)
      `CHK(grant, e_gr)
      `CHK({lk.halt_acknowledge, hreq}, {e_ack, e_hr})
      `CHK({tpw, evo}, {e_tp, e_ev})
      `CHK({lk.trace_power_up, lk.external_only_debug_write}, ctrl_m[7:0])
      `CHK(lk.trace_external_event, ev_m[7:0])
      `CHK(lk.instr_trace_ctrl, e_ic)
      `CHK({lk.instr_trace_address, lk.data_trace_ctrl}, {e_ia, e_dc})
      `CHK({lk.data_trace_address, lk.data_trace_write_value}, {e_da, e_dd})
      `CHK(lk.trace_context_id, e_ci)
      `CHK(lk.perf_event_bus, e_pf)
      `CHK(lk.wait_entry_pending, e_wp)
    end
  end

  task automatic wr_reg(input reg_addr_t a, input word_t d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    if (a == `REG_CTRL) ctrl_m = d;
    if (a == `REG_EXT_EV) ev_m = d;
  endtask : wr_reg

  // Read and compare the bits selected by m
  task automatic rd_chk(input reg_addr_t a, input word_t e, input word_t m);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1;
    `CHK(rdata & m, e)
  endtask : rd_chk

  task automatic stop_test();
    if (err_count == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    seed = 32948;
    {err_count, total_checks, rnd_on, chk_on, ctrl_m, ev_m} = '0;
    {rx_fill, rx_drain, tx_fill, tx_drain, npd, rwr, rext, halted, wait_for_interrupt_state} = '0;
    {ictl, dctl, perf, iaddr, daddr, dval, cid} = '0;
    {wr, rd, addr, wdata} = '0;
    rst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    #1 chk_on = 1'b1;
    `CHK({rom_ok, dbg_ok, rom_a, dbg_a}, {2'b10, RB, 12'h000, RB, 12'h000})
    rd_chk(`REG_IRQ_STAT, 32'h0000_00F0, 32'hFFFF_FFFF);
    rnd_on = 1'b1;
    repeat (40) begin
      wr_reg(`REG_CTRL, 32'($random(seed)) & 32'h0000_00FF);
      wr_reg(`REG_EXT_EV, 32'($random(seed)));
      repeat (5) @(posedge clk_i);
    end
    #1 rnd_on = 1'b0;
    // Quiet the inputs, drain both halves, then clear stale status
    @(posedge clk_i);
    {rx_fill, tx_fill, npd, rwr, rext, halted, wait_for_interrupt_state} <= '0;
    {rx_drain, tx_drain} <= '1;
    @(posedge clk_i);
    {rx_drain, tx_drain} <= '0;
    wr_reg(`REG_CTRL, 32'h0000_00F1);
    repeat (3) @(posedge clk_i);
    rd_chk(`REG_IRQ_STAT, 32'h0, 32'h0);
    // Flags are quiet now, so a second read must find the status empty
    rd_chk(`REG_IRQ_STAT, 32'h0, 32'hFFFF_FFFF);
    // Unmasked receive-full rise raises the line; masked one only sets status
    wr_reg(`REG_IRQ_MASK, 32'h0000_0001);
    @(posedge clk_i);
    rx_fill <= 4'h1;
    @(posedge clk_i);
    rx_fill <= 4'h2;
    rx_drain <= 4'h2;
    rwr <= 4'h3;
    @(posedge clk_i);
    {rx_fill, rx_drain, rwr} <= '0;
    repeat (3) @(posedge clk_i);
    #1 `CHK(irq, 1'b1)
    rd_chk(`REG_FLAGS, {16'h0, e_ack, e_kp, e_tx, e_rx}, 32'hFFFF_FFFF);
    rd_chk(`REG_IRQ_STAT, 32'h0000_0003, 32'h0000_FFFF);
    #1 `CHK(irq, 1'b0)
    // Halt handshake through the control register
    wr_reg(`REG_IRQ_MASK, 32'h0000_0100);
    wr_reg(`REG_CTRL, 32'h0000_01F1);
    @(posedge clk_i);
    halted <= 4'h1;
    repeat (3) @(posedge clk_i);
    #1 `CHK({irq, lk.external_halt_request}, 5'h10)
    rd_chk(`REG_IRQ_STAT, 32'h0000_0100, 32'h0000_0F00);
    // Trace readback of core 1, then with its port unpowered
    wr_reg(`REG_TRACE_SEL, 32'h1);
    rd_chk(`REG_T_CID, cid[1], 32'hFFFF_FFFF);
    rd_chk(`REG_T_ICTL, {12'h0, ictl[1]}, 32'hFFFF_FFFF);
    rd_chk(`REG_T_DADDR, daddr[1], 32'hFFFF_FFFF);
    rd_chk(`REG_T_PERF, {2'h0, perf[1]}, 32'hFFFF_FFFF);
    wr_reg(`REG_CTRL, 32'h0000_00D1);
    rd_chk(`REG_T_DDATA, 32'h0, 32'hFFFF_FFFF);
    wr_reg(8'hFC, 32'hFFFF_FFFF);
    rd_chk(8'hFC, 32'h0, 32'hFFFF_FFFF);
    stop_test();
  end

  // Watchdog far beyond the expected run length
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
endmodule : debug_sideband_signals_bench
`default_nettype wire
